// ### bench/slm_mapper_props.sv
// Checker on the lane mapper ports.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ns
module slm_props (
  input wire logic             clk_i,
  input wire logic             nrst_i,
  input wire logic             frame_valid_o,
  input wire logic             frame_ready_i,
  input wire logic [7:0][39:0] lane_data_o,
  input wire logic [7:0]       lane_en_o,
  input wire logic [2:0]       frame_octets_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  AST_EN_RUN: assert property (frame_valid_o |->
    lane_en_o[0] && (lane_en_o & (lane_en_o + 8'h01)) == 8'h00)
    else $error("lane enables not one run from lane zero");
  AST_OFF_ZERO: assert property (frame_valid_o && !lane_en_o[2] |->
    lane_data_o[2] == 40'h0 && lane_data_o[7] == 40'h0)
    else $error("disabled lane carries data");
  // Frame must stand untouched while the receiver stalls
  AST_HOLD: assert property (frame_valid_o && !frame_ready_i |=>
    frame_valid_o && $stable(lane_data_o) && $stable(lane_en_o))
    else $error("pending frame changed");
  AST_DROP: assert property (frame_valid_o && frame_ready_i |=>
    !frame_valid_o)
    else $error("frame valid stayed after accept");
  AST_OCT1: assert property (frame_valid_o && frame_octets_o == 3'h1
    |-> lane_data_o[0][31:0] == 32'h0)
    else $error("one-octet frame has extra data");
  AST_OCT2: assert property (frame_valid_o && frame_octets_o == 3'h2
    |-> lane_data_o[0][23:0] == 24'h0 && !lane_en_o[6])
    else $error("two-octet frame malformed");
  AST_OCT3: assert property (frame_valid_o && frame_octets_o == 3'h3
    |-> !lane_en_o[4] && lane_data_o[0][30:28] == 3'h0
    && lane_data_o[0][18:0] == 19'h0)
    else $error("container padding not zero");
  AST_OCT5: assert property (frame_valid_o && frame_octets_o == 3'h5
    |-> lane_en_o[1] && lane_data_o[0][30] == 1'b0
    && lane_data_o[0][20] == 1'b0 && lane_data_o[0][0] == 1'b0)
    else $error("ten-bit slot pad not zero");
  AST_RST: assert property (disable iff (1'b0) !nrst_i |=>
    !frame_valid_o && lane_en_o == 8'h00)
    else $error("outputs not cleared by reset");
endmodule : slm_props
bind slm_mapper slm_props u_props (.clk_i, .nrst_i, .frame_valid_o,
  .frame_ready_i, .lane_data_o, .lane_en_o, .frame_octets_o);

// ### bench/slm_mapper_tb_top.sv
// Bench for the lane mapper: frame table, reset, bad mode, fill.
// Assumes the sink model and the bound checker.
`timescale 1ns/1ns
module slm_mapper_tb_top import slm_pkg::*;;
  typedef struct packed {
    logic [3:0] m; logic [1:0] v; logic [39:0] l0; logic [39:0] l1;
    logic [7:0] en; logic [2:0] oc;
  } slm_row_t;
  localparam logic [35:0] DAT = {9'h0cc, 9'h133, 9'h0aa, 9'h155};
  localparam int NROW = 14;
  // Odd beats carry the inverted samples
  localparam slm_row_t ROWS [NROW] = '{
    '{4'h7, 2'h0, 40'haa00000000, 40'h5500000000, 8'h0f, 3'h1},
    '{4'h7, 2'h2, 40'haa00000000, 40'h0, 8'h01, 3'h1},
    '{4'h5, 2'h1, 40'haa55000000, 40'h0, 8'h01, 3'h2},
    '{4'h5, 2'h2, 40'haa00000000, 40'h0, 8'h01, 3'h2},
    '{4'h5, 2'h0, 40'haa55000000, 40'h9966000000, 8'h03, 3'h2},
    '{4'h4, 2'h0, 40'haa85000000, 40'h5099000000, 8'h07, 3'h2},
    '{4'h4, 2'h1, 40'haa85000000, 40'h5000000000, 8'h03, 3'h2},
    '{4'h4, 2'h2, 40'haa80000000, 40'h0, 8'h01, 3'h2},
    '{4'h6, 2'h1, 40'haa85000000, 40'h5055000000, 8'h07, 3'h2},
    '{4'h6, 2'h2, 40'haa85000000, 40'h5000000000, 8'h03, 3'h2},
    '{4'h8, 2'h0, 40'haa85500000, 40'h550aa80000, 8'h0f, 3'h3},
    '{4'h9, 2'h0, 40'haa00000000, 40'h5500000000, 8'hff, 3'h1},
    '{4'ha, 2'h2, 40'haaaaaaaaaa, 40'h5515455154, 8'h03, 3'h5},
    '{4'h4, 2'h3, 40'haa80000000, 40'h0, 8'h01, 3'h2}};
  logic                  clk_i, nrst_i, ce_i, smp_valid_i, smp_ready_o;
  logic                  frame_valid_o, frame_ready_i, mode_err_o;
  logic                  stall, hold;
  logic [3:0]            link_mapping_mode_i;
  logic [1:0]            variant_i;
  logic [35:0]           smp_data_i;
  logic [7:0][39:0]      lane_data_o, sk_lane;
  logic [7:0]            lane_en_o;
  logic [2:0]            frame_octets_o;
  int                    frames, miscompares, comparisons;
  slm_mapper uut (.clk_i, .nrst_i, .ce_i, .link_mapping_mode_i, .variant_i,
    .smp_valid_i, .smp_ready_o, .smp_data_i, .frame_valid_o, .frame_ready_i,
    .lane_data_o, .lane_en_o, .frame_octets_o, .mode_err_o);
  slm_sink u_sink (.clk_i, .nrst_i, .stall_i(stall), .hold_i(hold),
    .valid_i(frame_valid_o), .lane_i(lane_data_o), .ready_o(frame_ready_i),
    .lane_o(sk_lane), .frames_o(frames));
  // 100 ns period
  always #50 clk_i = ~clk_i;
  task automatic report_and_stop();
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk_lane(input logic [39:0] g, input logic [39:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t lane %h want %h", $time, g, e);
    end
  endtask : chk_lane
  task automatic chk_bit(input logic g, input logic e);
    chk_lane({39'h0, g}, {39'h0, e});
  endtask : chk_bit
  task automatic give_up();
    miscompares++;
    report_and_stop();
  endtask : give_up
  // Called just after an edge; returns at the edge that takes the beat
  task automatic put(input logic [35:0] d);
    int k;
    smp_valid_i <= 1'b1;
    smp_data_i  <= d;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (smp_ready_o !== 1'b1 && k < 40);
    if (smp_ready_o !== 1'b1) give_up();
    @(posedge clk_i);
  endtask : put
  task automatic wait_frame(input int t);
    int k;
    for (k = 0; k < 400 && frames != t; k++) @(negedge clk_i);
    if (frames != t) give_up();
  endtask : wait_frame
  initial begin
    slm_row_t r;
    int       n;
    {clk_i, nrst_i, ce_i, smp_valid_i, stall, hold} = 6'b001000;
    {link_mapping_mode_i, variant_i, smp_data_i} = '0;
    {miscompares, comparisons} = '0;
    repeat (11) @(posedge clk_i);
    @(negedge clk_i);
    chk_bit(frame_valid_o, 1'b0);
    chk_lane({32'h0, lane_en_o}, 40'h0);
    @(posedge clk_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < NROW; i++) begin
      r = ROWS[i];
      @(posedge clk_i);
      link_mapping_mode_i <= r.m;
      variant_i <= r.v;
      stall <= i[0];
      n = (r.m == 4'h6 || r.m == 4'h8 || r.m == 4'h9) ? 2 : 1;
      n = (r.m == 4'ha) ? 8 : n;
      for (int k = 0; k < n; k++) put(k[0] ? ~DAT : DAT);
      smp_valid_i <= 1'b0;
      wait_frame(i + 1);
      chk_lane(sk_lane[0], r.l0);
      chk_lane(sk_lane[1], r.l1);
      chk_lane({32'h0, lane_en_o}, {32'h0, r.en});
      chk_lane({37'h0, frame_octets_o}, {37'h0, r.oc});
      chk_bit(mode_err_o, 1'b0);
    end
    // Out-of-range mode: beat swallowed, no frame
    @(posedge clk_i);
    link_mapping_mode_i <= 4'h3;
    put(DAT);
    smp_valid_i <= 1'b0;
    @(negedge clk_i);
    chk_bit(mode_err_o, 1'b1);
    repeat (10) @(posedge clk_i);
    chk_bit(frames == NROW, 1'b1);
    link_mapping_mode_i <= 4'h7;
    variant_i <= 2'h0;
    hold <= 1'b1;
    ce_i <= 1'b0;
    @(negedge clk_i);
    chk_bit(smp_ready_o, 1'b0);
    // Receiver held off: FIFO fills until refusal
    @(posedge clk_i);
    ce_i <= 1'b1;
    smp_valid_i <= 1'b1;
    n = 0;
    repeat (20) begin
      @(negedge clk_i);
      if (smp_ready_o === 1'b1) n++;
    end
    chk_bit(smp_ready_o, 1'b0);
    // One beat sits in the mapper, the rest fill the FIFO
    chk_bit(n == FIFO_D + 1, 1'b1);
    @(posedge clk_i);
    smp_valid_i <= 1'b0;
    hold <= 1'b0;
    wait_frame(NROW + n);
    chk_lane(sk_lane[3], 40'h6600000000);
    report_and_stop();
  end
endmodule : slm_mapper_tb_top

// ### bench/slm_sink.sv
// Frame sink standing for the link receiver logic.
// Assumes the bench drives its stall and hold inputs.
`timescale 1ns/1ns
module slm_sink (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             stall_i,
  input  wire logic             hold_i,
  input  wire logic             valid_i,
  input  wire logic [7:0][39:0] lane_i,
  output logic                  ready_o,
  output logic [7:0][39:0]      lane_o,
  output int                    frames_o
);
  logic [1:0] tick_r;
  // Slow mode accepts on one edge in four
  assign ready_o = !hold_i && (!stall_i || tick_r == 2'h3);
  // Latch every accepted frame
  always @(posedge clk_i) begin
    tick_r <= nrst_i ? tick_r + 2'h1 : 2'h0;
    if (!nrst_i) frames_o <= 0;
    else if (valid_i && ready_o) begin
      lane_o   <= lane_i;
      frames_o <= frames_o + 1;
    end
  end
endmodule : slm_sink

// ### rtl/slm_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; ce_i low freezes all state.
`timescale 1ns/1ns
module slm_fifo #(
  parameter int W     = 36,
  parameter int DEPTH = 8
) (
  input  wire logic   clk_i,
  input  wire logic   nrst_i,
  input  wire logic   ce_i,
  slm_stream_if.snk   wr,
  slm_stream_if.src   rd
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  cnt_r;
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic          push;
  logic          pop;

  // Honest full and empty from the occupancy count
  assign wr.ready = (cnt_r != (AW+1)'(DEPTH)) && ce_i;
  assign rd.valid = (cnt_r != '0) && ce_i;
  assign rd.data  = mem[rp_r];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  // Storage, no reset needed on the data itself
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_r] <= wr.data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (ce_i) begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : slm_fifo

// ### rtl/slm_mapper.sv
// Transmit lane mapper: gathers converter samples of channels A to D and
// packs them into the octets of the serial lanes for mapping modes 4..10.
// Assumes line coding, scrambling and framing happen downstream, and that
// the sample source and the lane consumer share clk_i.
// Operation
// - Mode 4: 9-bit samples on 3/2/1 lanes; lane zero ends with B0[8:5] or 0.
// - Mode 5: 8-bit samples, lane zero A then B or 0x00, lane one C, D.
// - Mode 6: 9-bit plus 000, channel pairs A/B and C/D share lane triples, 6/3/2.
// - Mode 7: one octet per lane, lanes zero to three carry A to D.
// - Mode 8: two 12-bit containers per lane, one channel per lane.
// - Mode 9: one octet per lane, two lanes per channel, samples 0 and 1.
// - Mode 10: 9-bit plus 0, four samples in five octets, even/odd lanes.
// - Lanes beyond the variant's count stay inactive.
`timescale 1ns/1ns
module slm_mapper
  import slm_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_D
) (
  input  wire logic                           clk_i,
  input  wire logic                           nrst_i,
  input  wire logic                           ce_i,
  input  wire logic [3:0]                     link_mapping_mode_i,
  input  wire logic [1:0]                     variant_i,
  input  wire logic                           smp_valid_i,
  output logic                                smp_ready_o,
  input  wire logic [NCH*SMP_W-1:0]           smp_data_i,
  output logic                                frame_valid_o,
  input  wire logic                           frame_ready_i,
  output logic [NLANE-1:0][LANE_W-1:0]        lane_data_o,
  output logic [NLANE-1:0]                    lane_en_o,
  output logic [2:0]                          frame_octets_o,
  output logic                                mode_err_o
);

  typedef enum logic [2:0] {
    ST_COLLECT = 3'b001,
    ST_MAP     = 3'b010,
    ST_SEND    = 3'b100
  } slm_state_t;

  slm_stream_if #(.W(NCH*SMP_W)) in_if ();
  slm_stream_if #(.W(NCH*SMP_W)) out_if ();

  slm_state_t                  state_r;
  logic [3:0]                  mode_r;
  logic [1:0]                  var_r;
  logic [3:0]                  beat_r;
  logic [3:0]                  mode_cur;
  logic [1:0]                  var_cur;
  logic                        take;
  logic [SMP_W-1:0]            smp_r [NCH][MAX_SMP];
  logic [SMP_W-1:0]            ch    [NCH][MAX_SMP];
  logic [NLANE-1:0][LANE_W-1:0] lanes_nxt;
  logic [3:0]                  nl;

  // Source side of the FIFO is the block's own input port
  assign in_if.valid = smp_valid_i;
  assign in_if.data  = smp_data_i;
  assign smp_ready_o = in_if.ready;

  slm_fifo #(
    .W     (NCH*SMP_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .ce_i   (ce_i),
    .wr     (in_if),
    .rd     (out_if)
  );

  // The frame's mode is taken at its first beat and kept to its end, so a
  // change of the mode pins mid-frame cannot tear a frame apart.
  assign mode_cur = (beat_r == 4'h0) ? link_mapping_mode_i : mode_r;
  assign var_cur  = (beat_r == 4'h0) ? variant_i : var_r;
  assign mode_err_o = !slm_mode_ok(mode_cur);

  // Drain only while collecting; unknown modes are drained and dropped so
  // the source never locks up behind them.
  assign out_if.ready = (state_r == ST_COLLECT) && ce_i;
  assign take         = out_if.valid && out_if.ready;

  // Frame sequencer
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_r <= ST_COLLECT;
      beat_r  <= 4'h0;
      mode_r  <= MODE_Q9_3L;
      var_r   <= VAR_QUAD;
    end else if (ce_i) begin
      case (state_r)
        ST_COLLECT: begin
          if (take && slm_mode_ok(mode_cur)) begin
            mode_r <= mode_cur;
            var_r  <= var_cur;
            if (beat_r == slm_beats(mode_cur) - 4'h1) begin
              beat_r  <= 4'h0;
              state_r <= ST_MAP;
            end else begin
              beat_r <= beat_r + 4'h1;
            end
          end
        end
        ST_MAP: state_r <= ST_SEND;
        ST_SEND: begin
          if (frame_ready_i) begin
            state_r <= ST_COLLECT;
          end
        end
        default: state_r <= ST_COLLECT;
      endcase
    end
  end

  // Sample store, one column per input beat
  always_ff @(posedge clk_i) begin
    if (ce_i && take && (state_r == ST_COLLECT)) begin
      for (int c = 0; c < NCH; c++) begin
        smp_r[c][beat_r[2:0]] <= out_if.data[c*SMP_W +: SMP_W];
      end
    end
  end

  // Channels the variant does not carry read as zero, which gives the
  // zero fill of their octets on the lanes that remain active.
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      for (int k = 0; k < MAX_SMP; k++) begin
        // Code 3 is no listed variant, so it is read as single
        if ((var_r == VAR_DUAL && c > 1) ||
            (var_r != VAR_QUAD && var_r != VAR_DUAL && c > 0)) begin
          ch[c][k] = '0;
        end else begin
          ch[c][k] = smp_r[c][k];
        end
      end
    end
  end

  // Lane packing; octet 0 sits in the top byte of each lane word
  always_comb begin
    lanes_nxt = '0;
    case (mode_r)
      MODE_Q9_3L: begin
        lanes_nxt[0] = {ch[0][0], 3'h0, ch[1][0][8:5], 24'h0};
        lanes_nxt[1] = {ch[1][0][4:0], 3'h0, ch[2][0][8:1],
                        24'h0};
        lanes_nxt[2] = {ch[2][0][0], 3'h0, ch[3][0], 3'h0,
                        24'h0};
      end
      MODE_Q8_2L: begin
        lanes_nxt[0] = {ch[0][0][8:1], ch[1][0][8:1], 24'h0};
        lanes_nxt[1] = {ch[2][0][8:1], ch[3][0][8:1], 24'h0};
      end
      MODE_Q9_6L: begin
        // A/B share lanes 0..2, C/D share lanes 3..5
        for (int g = 0; g < 2; g++) begin
          lanes_nxt[3*g]   = {ch[2*g][0], 3'h0, ch[2*g][1][8:5],
                              24'h0};
          lanes_nxt[3*g+1] = {ch[2*g][1][4:0], 3'h0,
                              ch[2*g+1][0][8:1], 24'h0};
          lanes_nxt[3*g+2] = {ch[2*g+1][0][0], 3'h0,
                              ch[2*g+1][1], 3'h0, 24'h0};
        end
      end
      MODE_Q8_4L: begin
        for (int c = 0; c < NCH; c++) begin
          lanes_nxt[c] = {ch[c][0][8:1], 32'h0};
        end
      end
      MODE_Q12_4L: begin
        for (int c = 0; c < NCH; c++) begin
          lanes_nxt[c] = {ch[c][0], 3'h0, ch[c][1], 3'h0, 16'h0};
        end
      end
      MODE_E8_8L: begin
        for (int c = 0; c < NCH; c++) begin
          for (int k = 0; k < 2; k++) begin
            lanes_nxt[2*c+k] = {ch[c][k][8:1], 32'h0};
          end
        end
      end
      MODE_E9_8L: begin
        for (int c = 0; c < NCH; c++) begin
          for (int k = 0; k < 2; k++) begin
            lanes_nxt[2*c+k] = {ch[c][k], 1'b0, ch[c][k+2], 1'b0,
                                ch[c][k+4], 1'b0, ch[c][k+6],
                                1'b0};
          end
        end
      end
      default: lanes_nxt = '0;
    endcase
  end

  assign nl = slm_lanes(mode_r, var_r);

  // Output frame registers; held stable while the consumer stalls
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      frame_valid_o  <= 1'b0;
      lane_data_o    <= '0;
      lane_en_o      <= '0;
      frame_octets_o <= 3'h0;
    end else if (ce_i) begin
      if (state_r == ST_MAP) begin
        frame_valid_o  <= 1'b1;
        frame_octets_o <= slm_octets(mode_r);
        for (int l = 0; l < NLANE; l++) begin
          // Inactive lanes are forced to zero as well as disabled
          lane_en_o[l]   <= (4'(l) < nl);
          lane_data_o[l] <= (4'(l) < nl) ? lanes_nxt[l] : '0;
        end
      end else if (state_r == ST_SEND && frame_ready_i) begin
        frame_valid_o <= 1'b0;
      end
    end
  end

endmodule : slm_mapper

// ### rtl/slm_pkg.sv
// Package for the serial lane sample mapper: sizes, mode codes, variant
// codes and the per-mode framing tables.
// Assumes the samples are 9 bits wide and that 8-bit modes take the MSBs.
package slm_pkg;

  localparam int NCH     = 4;   // Channels A to D
  localparam int MAX_SMP = 8;   // Most samples per channel in one frame
  localparam int SMP_W   = 9;   // Converter sample width
  localparam int NLANE   = 8;   // Lanes lane_zero to lane_seven
  localparam int LANE_W  = 40;  // Widest lane frame, five octets
  localparam int FIFO_D  = 8;   // Sample FIFO depth

  localparam logic [3:0] MODE_Q9_3L  = 4'h4;  // 9-bit, 3/2/1 lanes
  localparam logic [3:0] MODE_Q8_2L  = 4'h5;  // 8-bit, 2/1/1 lanes
  localparam logic [3:0] MODE_Q9_6L  = 4'h6;  // 9-bit padded, 6/3/2 lanes
  localparam logic [3:0] MODE_Q8_4L  = 4'h7;  // 8-bit, 4/2/1 lanes
  localparam logic [3:0] MODE_Q12_4L = 4'h8;  // 12-bit container
  localparam logic [3:0] MODE_E8_8L  = 4'h9;  // 8-bit, 8B/10B, 8/4/2
  localparam logic [3:0] MODE_E9_8L  = 4'ha;  // 9-bit + 1, 8B/10B, 8/4/2

  typedef enum logic [1:0] {
    VAR_QUAD   = 2'h0,
    VAR_DUAL   = 2'h1,
    VAR_SINGLE = 2'h2
  } slm_variant_t;

  // Modes handled by this mapper
  function automatic logic slm_mode_ok(input logic [3:0] m);
    return (m >= MODE_Q9_3L) && (m <= MODE_E9_8L);
  endfunction : slm_mode_ok

  // Input beats (one sample per channel each) gathered per frame
  function automatic logic [3:0] slm_beats(input logic [3:0] m);
    case (m)
      MODE_Q9_6L, MODE_Q12_4L, MODE_E8_8L: return 4'h2;
      MODE_E9_8L: return 4'h8;
      default: return 4'h1;
    endcase
  endfunction : slm_beats

  // Octets each lane carries per frame
  function automatic logic [2:0] slm_octets(input logic [3:0] m);
    case (m)
      MODE_Q8_4L, MODE_E8_8L: return 3'h1;
      MODE_Q12_4L: return 3'h3;
      MODE_E9_8L: return 3'h5;
      default: return 3'h2;
    endcase
  endfunction : slm_octets

  // Lanes driven for a mode and variant
  function automatic logic [3:0] slm_lanes(input logic [3:0] m,
                                           input logic [1:0] v);
    logic [3:0] q;
    logic [3:0] d;
    logic [3:0] s;
    q = 4'h4;
    d = 4'h2;
    s = 4'h1;
    case (m)
      MODE_Q9_3L: begin q = 4'h3; d = 4'h2; s = 4'h1; end
      MODE_Q8_2L: begin q = 4'h2; d = 4'h1; s = 4'h1; end
      MODE_Q9_6L: begin q = 4'h6; d = 4'h3; s = 4'h2; end
      MODE_E8_8L, MODE_E9_8L: begin q = 4'h8; d = 4'h4; s = 4'h2; end
      default: begin q = 4'h4; d = 4'h2; s = 4'h1; end
    endcase
    case (v)
      VAR_QUAD: return q;
      VAR_DUAL: return d;
      default:  return s;
    endcase
  endfunction : slm_lanes

endpackage : slm_pkg

// ### rtl/slm_stream_if.sv
// Valid/ready carrier between the sample FIFO and the mapper core.
// Assumes both ends share clk_i.
`timescale 1ns/1ns
interface slm_stream_if #(
  parameter int W = 36
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : slm_stream_if
